// ==== hw/debug_unit_consts.vh ====
`ifndef DEBUG_UNIT_CONSTS_VH
`define DEBUG_UNIT_CONSTS_VH
// Register addresses on the debug link
`define DU_ADDR_BK1E   16'h7f90
`define DU_ADDR_BK1H   16'h7f91
`define DU_ADDR_BK1L   16'h7f92
`define DU_ADDR_BK2E   16'h7f93
`define DU_ADDR_BK2H   16'h7f94
`define DU_ADDR_COMPARATOR2_LOW_BYTE   16'h7f95
`define DU_ADDR_CR1    16'h7f96
`define DU_ADDR_CR2    16'h7f97
`define DU_ADDR_CSR1   16'h7f98
`define DU_ADDR_CSR2   16'h7f99
// Reset values
`define DU_RST_BK      8'hff
`define DU_RST_CR      8'h00
`define DU_RST_CSR1    8'h10
`define DU_RST_CSR2    8'h00
// Writable masks
`define DU_CR1_MASK    8'hbe
`define DU_CR2_MASK    8'h05
// Field positions
`define DU_WDG_BIT     7
`define DU_BC_HI       5
`define DU_BC_LO       3
`define DU_BIR_BIT     2
`define DU_BIW_BIT     1
`define DU_ROM_BIT     2
`define DU_RAM_BIT     0
`define DU_STE_BIT     6
`define DU_STF_BIT     5
`define DU_RSTF_BIT    4
`define DU_BRW_BIT     3
`define DU_COMPARATOR2_HIT_FLAG_BIT    2
`define DU_COMPARATOR1_HIT_FLAG_BIT    1
`define DU_SOFT_BREAK_ENABLE_BIT   5
`define DU_SOFT_BREAK_FLAG_BIT   4
`define DU_HALT_BIT    3
`define DU_FLUSH_BIT   0
// Break condition codes
`define DU_BC_DATA     3'h0
`define DU_BC_IN       3'h1
`define DU_BC_OUT      3'h2
`define DU_BC_OFF3     3'h3
`define DU_BC_EQ_THEN  3'h4
`define DU_BC_EQ_OR    3'h5
`define DU_BC_OFF6     3'h6
`define DU_BC_STACK    3'h7
// Software break opcode
`define DU_SWBK_OP     8'h8b
`endif

// ==== hw/debug_breakpoint_stall_unit.v ====
`timescale 1ns/1ps
`default_nettype none
`include "debug_unit_consts.vh"

// Contract
// R1: Fetch match stalls in decode, before execute
// R2: Invalid instruction address never stalls
// R3: Step mode stalls at first decode cycle
// R4: Step plus break sets both flags
// R5: Break holds core stalled for host access
// R6: Host sets flush before clearing halt
// R7: Registers reached only over debug link
// R8: Comparator1 address three bytes, reset ones
// R9: Comparator2 address three bytes, reset ones
// R10: Watchdog freeze while stalled, unless hardware
// R11: Condition field selects match condition
// R12: Read and write break enables
// R13: Vector table remap to ROM or RAM
// R14: Step enable read/write bit
// R15: Step flag hardware only
// R16: Reset flag set on post-reset stall
// R17: Direction flag captures access kind
// R18: Comparator flags cleared with halt
// R19: Soft break enable gates opcode stall
// R20: Soft break flag cleared with halt
// R21: Halt bit stalls, forced off outside link
// R22: Flush bit cleared when flush done
// R23: Condition encodings per table
// R24: Soft break opcode recognised
// R25: Abort stalls immediately, no interrupt
// R26: Inactive link never stalls
module debug_breakpoint_stall_unit (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        nrst,
    // Debug link register access
    input  wire        link_active,
    input  wire        rd_on_fly_cmd,
    input  wire        wr_on_fly_cmd,
    input  wire [15:0] link_addr,
    input  wire [7:0]  link_wdata,
    output reg  [7:0]  link_rdata,
    // Core fetch/decode observation
    input  wire        dec_first,
    input  wire        dec_valid_insn,
    input  wire [23:0] dec_addr,
    input  wire [7:0]  dec_opcode,
    // Core data access observation
    input  wire        data_strobe,
    input  wire        data_rd,
    input  wire [23:0] data_addr,
    input  wire [7:0]  data_val,
    input  wire        data_stack,
    input  wire        insn_end,
    input  wire        reset_done,
    // Core control
    input  wire        hw_watchdog,
    input  wire        flush_done,
    output wire        core_halt_signal,
    output wire        decode_flush,
    output wire        watchdog_freeze,
    output wire        vectors_to_rom,
    output wire        vectors_to_ram
);

    // Comparator addresses, built from three byte writes
    reg [23:0] bk1_reg;
    reg [23:0] bk2_reg;

    // Control images, reserved bits masked on write
    reg [7:0]  cr1_reg;
    reg [7:0]  cr2_reg;

    // Step enable and hardware-only status flags
    reg        step_enable_reg;
    reg        step_flag_reg;
    reg        reset_flag_reg;
    reg        dir_reg;
    reg        hit1_reg;
    reg        hit2_reg;

    // Soft break enable and its flag
    reg        soft_break_enable_reg;
    reg        soft_break_flag_reg;

    // Halt and flush, both dropped while the link is down
    reg        halt_reg;
    reg        flush_reg;

    // Two-stage fetch match state
    reg        seq_armed_reg;

    // Reset stall fires once only
    reg        rst_pend_reg;

    // Data match held to the instruction end, so a
    // stall never splits an access in two
    reg        data_pend_reg;
    reg        data_pend_next;
    reg        pend_h1_reg;
    reg        pend_h2_reg;
    reg        pend_dir_reg;

    // Condition field and access enables
    wire [2:0] bc = cr1_reg[`DU_BC_HI:`DU_BC_LO];
    wire       read_break_enable = cr1_reg[`DU_BIR_BIT];
    wire       write_break_enable = cr1_reg[`DU_BIW_BIT];

    // Access kind allowed by the enable bits
    // (a read needs the read enable, a write the write one)
    function dir_ok;
        input r;
        input en_r;
        input en_w;
        begin
            dir_ok = r ? en_r : en_w;
        end
    endfunction

    // Write decode used by every register
    function wr_hit;
        input [15:0] a;
        input [15:0] target;
        begin
            wr_hit = wr_on_fly_cmd && link_active && (a == target); // R7
        end
    endfunction

    // Address compares, one set for the fetch path and one for the data path
    // Range compares include both end points
    wire f_eq1 = dec_addr == bk1_reg;
    wire f_eq2 = dec_addr == bk2_reg;
    wire f_in  = (dec_addr >= bk1_reg) && (dec_addr <= bk2_reg);
    wire f_out = (dec_addr <= bk1_reg) || (dec_addr >= bk2_reg);

    wire d_eq1 = data_addr == bk1_reg;
    wire d_eq2 = data_addr == bk2_reg;
    wire d_in  = (data_addr >= bk1_reg) && (data_addr <= bk2_reg);
    wire d_out = (data_addr <= bk1_reg) || (data_addr >= bk2_reg);
    wire d_dir = dir_ok(data_rd, read_break_enable, write_break_enable); // R12

    // Only a real instruction's first decode may break
    wire fetch = dec_first && dec_valid_insn; // R1 R2

    // Fetch-side comparator hits
    reg fh1;
    reg fh2;
    always @* begin // R11 R23
        fh1 = 1'b0;
        fh2 = 1'b0;
        case (bc)
            `DU_BC_IN:      fh1 = fetch && !read_break_enable && !write_break_enable && f_in;
            `DU_BC_OUT:     fh1 = fetch && !read_break_enable && !write_break_enable && f_out;
            `DU_BC_EQ_THEN: begin
                fh2 = fetch && !read_break_enable && !write_break_enable && f_eq2 && seq_armed_reg;
            end
            `DU_BC_EQ_OR: begin
                fh1 = fetch && f_eq1;
                fh2 = fetch && !read_break_enable && !write_break_enable && f_eq2;
            end
            `DU_BC_STACK:   fh2 = fetch && !read_break_enable && !write_break_enable && f_eq2;
            // Codes 011, 110 and plain 000 match no fetch
            default: begin
                fh1 = 1'b0;
                fh2 = 1'b0;
            end
        endcase
    end

    // Data-side comparator hits
    reg dh1;
    reg dh2;
    always @* begin // R11 R12 R17 R23
        dh1 = 1'b0;
        dh2 = 1'b0;
        case (bc)
            `DU_BC_DATA:    dh1 = data_strobe && d_dir && d_eq1 && (data_val == bk2_reg[7:0]);
            `DU_BC_IN:      dh1 = data_strobe && d_dir && d_in;
            `DU_BC_OUT:     dh1 = data_strobe && d_dir && d_out;
            `DU_BC_EQ_THEN: begin
                dh1 = data_strobe && d_dir && d_eq1;
                dh2 = data_strobe && d_dir && d_eq2;
            end
            `DU_BC_EQ_OR:   dh2 = data_strobe && d_dir && d_eq2;
            `DU_BC_STACK: begin
                dh1 = data_strobe && !data_rd && data_stack && (data_addr <= bk1_reg);
                dh2 = data_strobe && (read_break_enable || write_break_enable) && d_dir && d_eq2;
            end
            // Codes 011 and 110 match no access
            default: begin
                dh1 = 1'b0;
                dh2 = 1'b0;
            end
        endcase
    end

    // Event sources; nothing reaches the core while the link is down
    // Step and a fetch match may fire together, setting both flags
    // The reset stall waits for reset_done after reset
    wire seq_first = fetch && (bc == `DU_BC_EQ_THEN) && !read_break_enable && !write_break_enable && f_eq1;
    wire step_ev   = link_active && step_enable_reg && fetch; // R3 R26
    wire swbk_ev   = link_active && soft_break_enable_reg && fetch
                     && (dec_opcode == `DU_SWBK_OP); // R19 R24
    wire fetch_ev  = link_active && (fh1 || fh2); // R1 R26
    wire data_fire = link_active && data_pend_reg && insn_end;
    wire rst_ev    = link_active && rst_pend_reg && reset_done; // R16
    wire any_ev    = step_ev || swbk_ev || fetch_ev || data_fire || rst_ev;

    // Host writes to the halt bit
    // Bit 3 high aborts at once, bit 3 low resumes
    wire csr2_wr  = wr_hit(link_addr, `DU_ADDR_CSR2);
    wire halt_set = csr2_wr && link_wdata[`DU_HALT_BIT];
    wire halt_clr = csr2_wr && !link_wdata[`DU_HALT_BIT];

    // A new event wins over a host clear in the same cycle
    wire clr_flags = halt_clr && !any_ev;

    // Stall is combinational so abort and decode breaks act at once
    // Trade-off: a path from decode back to the core, in place of
    // a registered stall that would let one more decode through
    assign core_halt_signal = link_active && (halt_reg || any_ev || halt_set); // R1 R5 R21 R25
    assign decode_flush     = flush_reg; // R22
    assign watchdog_freeze  = cr1_reg[`DU_WDG_BIT] && !hw_watchdog && core_halt_signal; // R10
    assign vectors_to_rom   = cr2_reg[`DU_ROM_BIT]; // R13
    assign vectors_to_ram   = cr2_reg[`DU_RAM_BIT]; // R13

    // Data breaks wait for the end of the current instruction
    // A match in the end cycle itself waits for the next end
    always @* begin
        data_pend_next = data_pend_reg;
        if (insn_end) begin
            data_pend_next = 1'b0;
        end
        if (dh1 || dh2) begin
            data_pend_next = 1'b1;
        end
    end

    // Configuration registers
    always @(posedge clk_sys) begin
        if (!nrst) begin
            bk1_reg <= {3{`DU_RST_BK}}; // R8
            bk2_reg <= {3{`DU_RST_BK}}; // R9
            cr1_reg <= `DU_RST_CR;
            cr2_reg <= `DU_RST_CR;
            step_enable_reg       <= 1'b0;
            soft_break_enable_reg <= 1'b0;
        end else begin
            // Each byte lands alone; the host writes all three
            if (wr_hit(link_addr, `DU_ADDR_BK1E)) bk1_reg[23:16] <= link_wdata; // R8
            if (wr_hit(link_addr, `DU_ADDR_BK1H)) bk1_reg[15:8]  <= link_wdata;
            if (wr_hit(link_addr, `DU_ADDR_BK1L)) bk1_reg[7:0]   <= link_wdata;
            if (wr_hit(link_addr, `DU_ADDR_BK2E)) bk2_reg[23:16] <= link_wdata; // R9
            if (wr_hit(link_addr, `DU_ADDR_BK2H)) bk2_reg[15:8]  <= link_wdata;
            if (wr_hit(link_addr, `DU_ADDR_COMPARATOR2_LOW_BYTE)) bk2_reg[7:0]   <= link_wdata;

            // Reserved control bits always read back zero
            if (wr_hit(link_addr, `DU_ADDR_CR1)) cr1_reg <= link_wdata & `DU_CR1_MASK;
            if (wr_hit(link_addr, `DU_ADDR_CR2)) cr2_reg <= link_wdata & `DU_CR2_MASK;
            if (wr_hit(link_addr, `DU_ADDR_CSR1)) begin
                step_enable_reg <= link_wdata[`DU_STE_BIT]; // R14
            end
            if (csr2_wr) begin
                soft_break_enable_reg <= link_wdata[`DU_SOFT_BREAK_ENABLE_BIT]; // R19
            end
        end
    end

    // Halt, flush and hardware status flags
    always @(posedge clk_sys) begin
        if (!nrst) begin
            // Reset flag starts set, so the status image is 10h
            halt_reg            <= 1'b0;
            flush_reg           <= 1'b0;
            step_flag_reg       <= 1'b0;
            reset_flag_reg      <= 1'b1; // R16
            dir_reg             <= 1'b0;
            hit1_reg            <= 1'b0;
            hit2_reg            <= 1'b0;
            soft_break_flag_reg <= 1'b0;
            seq_armed_reg       <= 1'b0;
            rst_pend_reg        <= 1'b1;
            data_pend_reg       <= 1'b0;
            pend_h1_reg         <= 1'b0;
            pend_h2_reg         <= 1'b0;
            pend_dir_reg        <= 1'b0;
        end else if (!link_active) begin
            // Link down: drop halt, flush and a pending data break so no stall leaks
            // to the core; comparator state is kept as it is
            halt_reg      <= 1'b0; // R21 R26
            flush_reg     <= 1'b0;
            data_pend_reg <= 1'b0;
        end else begin
            // Halt bit: events and abort set, host clear resumes
            if (any_ev || halt_set) begin
                halt_reg <= 1'b1; // R5 R21 R25
            end else if (halt_clr) begin
                halt_reg <= 1'b0; // R21
            end

            // Flush: set by host, hardware clears on completion
            if (csr2_wr && link_wdata[`DU_FLUSH_BIT]) begin
                flush_reg <= 1'b1; // R6 R22
            end else if (flush_done) begin
                flush_reg <= 1'b0; // R22
            end

            // Sticky flags clear with the halt bit
            if (clr_flags) begin
                step_flag_reg       <= 1'b0; // R15
                reset_flag_reg      <= 1'b0; // R16
                hit1_reg            <= 1'b0; // R18
                hit2_reg            <= 1'b0; // R18
                soft_break_flag_reg <= 1'b0; // R20
            end

            // Event flags; a set beats a clear in one cycle
            if (step_ev) step_flag_reg <= 1'b1; // R4 R15
            if (rst_ev) begin
                reset_flag_reg <= 1'b1; // R16
                rst_pend_reg   <= 1'b0;
            end
            if (swbk_ev) soft_break_flag_reg <= 1'b1; // R20
            if (fetch_ev && fh1) hit1_reg <= 1'b1; // R4 R18
            if (fetch_ev && fh2) hit2_reg <= 1'b1; // R4 R18
            if (data_fire) begin
                hit1_reg <= pend_h1_reg || (fetch_ev && fh1);
                hit2_reg <= pend_h2_reg || (fetch_ev && fh2);
                dir_reg  <= pend_dir_reg; // R17
            end

            // Two-stage match: arm on the first address
            if (seq_first) seq_armed_reg <= 1'b1;
            else if (fh2) seq_armed_reg <= 1'b0;

            // Pending data break and what it matched
            data_pend_reg <= data_pend_next;
            if (dh1 || dh2) begin
                pend_h1_reg  <= dh1;
                pend_h2_reg  <= dh2;
                pend_dir_reg <= data_rd; // R17
            end
        end
    end

    // Read-on-the-fly data; reserved bits read zero
    // The answer stands until the next read command
    always @(posedge clk_sys) begin
        if (!nrst) begin
            link_rdata <= 8'h00;
        end else if (rd_on_fly_cmd && link_active) begin // R7
            case (link_addr)
                `DU_ADDR_BK1E: link_rdata <= bk1_reg[23:16];
                `DU_ADDR_BK1H: link_rdata <= bk1_reg[15:8];
                `DU_ADDR_BK1L: link_rdata <= bk1_reg[7:0];
                `DU_ADDR_BK2E: link_rdata <= bk2_reg[23:16];
                `DU_ADDR_BK2H: link_rdata <= bk2_reg[15:8];
                `DU_ADDR_COMPARATOR2_LOW_BYTE: link_rdata <= bk2_reg[7:0];
                `DU_ADDR_CR1:  link_rdata <= cr1_reg;
                `DU_ADDR_CR2:  link_rdata <= cr2_reg;
                `DU_ADDR_CSR1: link_rdata <= {1'b0, step_enable_reg, step_flag_reg,
                                              reset_flag_reg, dir_reg, hit2_reg,
                                              hit1_reg, 1'b0};
                `DU_ADDR_CSR2: link_rdata <= {2'h0, soft_break_enable_reg,
                                              soft_break_flag_reg, halt_reg, 2'h0,
                                              flush_reg};
                default:       link_rdata <= 8'h00;
            endcase
        end
    end

endmodule // debug_breakpoint_stall_unit
`default_nettype wire

// ==== tb/debug_unit_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module debug_unit_checker (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        nrst,
    // Link side
    input wire logic        link_active,
    input wire logic        rd_on_fly_cmd,
    input wire logic        wr_on_fly_cmd,
    input wire logic [15:0] link_addr,
    input wire logic [7:0]  link_wdata,
    input wire logic [7:0]  link_rdata,
    // Core side
    input wire logic        hw_watchdog,
    input wire logic        flush_done,
    input wire logic        core_halt_signal,
    input wire logic        decode_flush,
    input wire logic        watchdog_freeze,
    input wire logic        vectors_to_rom,
    input wire logic        vectors_to_ram
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Decoded host commands shared by the checks
    logic wr2;
    logic rd_ok;
    assign wr2 = link_active && wr_on_fly_cmd && link_addr == 16'h7f99;
    assign rd_ok = link_active && rd_on_fly_cmd;
    a_no_link_stall: assert property (!link_active |-> !core_halt_signal)
        else $error("stall while link inactive");
    a_abort_now: assert property (wr2 && link_wdata[3] |-> core_halt_signal)
        else $error("abort did not stall at once");
    a_break_held: assert property (core_halt_signal && !wr2 ##1 link_active |-> core_halt_signal)
        else $error("stall dropped without resume");
    a_freeze_cause: assert property (watchdog_freeze |-> core_halt_signal && !hw_watchdog)
        else $error("watchdog frozen without stall");
    a_flush_set: assert property (wr2 && link_wdata[0] ##1 link_active |-> decode_flush)
        else $error("flush bit not set");
    a_flush_clear: assert property (decode_flush && flush_done && !wr2 |-> ##[1:2] !decode_flush)
        else $error("flush bit not cleared");
    a_remap_follow: assert property (link_active && wr_on_fly_cmd && link_addr == 16'h7f97 |=>
        vectors_to_rom == $past(link_wdata[2]) && vectors_to_ram == $past(link_wdata[0]))
        else $error("vector remap mismatch");
    a_rdata_hold: assert property (!rd_ok |=> $stable(link_rdata))
        else $error("read data moved without read");
    a_unmapped_zero: assert property (rd_ok && (link_addr < 16'h7f90 || link_addr > 16'h7f99)
        |=> link_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // debug_unit_checker
`default_nettype wire

// ==== tb/debug_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module debug_host_model (
    // Clock
    input  wire logic        clk_sys,
    // Link commands
    output var logic         rd_on_fly_cmd,
    output var logic         wr_on_fly_cmd,
    output var logic [15:0]  link_addr,
    output var logic [7:0]   link_wdata,
    // Read answer due
    output var logic         rvalid
);
    // Idle strobes low at start
    initial begin
        rd_on_fly_cmd = 1'b0;
        wr_on_fly_cmd = 1'b0;
        link_addr = 16'h0000;
        link_wdata = 8'h00;
    end
    // Answer is registered at the strobe edge, so it is due one edge later
    always @(posedge clk_sys) rvalid <= rd_on_fly_cmd;
    // Write on the fly; released lines show the inverse, never a stale value
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        wr_on_fly_cmd = 1'b1;
        link_addr = a;
        link_wdata = d;
        @(posedge clk_sys);
        #1;
        wr_on_fly_cmd = 1'b0;
        link_addr = ~a;
        link_wdata = ~d;
    endtask
    // Read on the fly, one strobe cycle
    task automatic rd(input logic [15:0] a);
        @(posedge clk_sys);
        #1;
        rd_on_fly_cmd = 1'b1;
        link_addr = a;
        @(posedge clk_sys);
        #1;
        rd_on_fly_cmd = 1'b0;
        link_addr = ~a;
    endtask
endmodule // debug_host_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk_sys, nrst, link_active, rd_on_fly_cmd, wr_on_fly_cmd, rvalid;
    logic        dec_first, dec_valid_insn, data_strobe, data_rd, data_stack, insn_end;
    logic        reset_done, hw_watchdog, flush_done, core_halt_signal, decode_flush;
    logic        watchdog_freeze, vectors_to_rom, vectors_to_ram;
    logic [15:0] link_addr;
    logic [7:0]  link_wdata, link_rdata, dec_opcode, data_val;
    logic [23:0] dec_addr, data_addr;
    logic [7:0]  exp_q[$];
    logic [31:0] seed;
    int          fail_count, checks, i;
    logic [7:0]  rst_tab[10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00,
                                 8'h10, 8'h08};
    logic [7:0]  bk_tab[6] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h10, 8'h10};
    logic [7:0]  bc_tab[8] = '{8'h08, 8'h08, 8'h08, 8'h10, 8'h10, 8'h18, 8'h30, 8'h00};
    logic [23:0] fa_tab[8] = '{24'h001008, 24'h001008, 24'h002000, 24'h002000, 24'h001008,
                               24'h001000, 24'h001000, 24'h001000};
    logic [7:0]  fv = 8'hfd;
    logic [7:0]  fe = 8'h09;
    debug_breakpoint_stall_unit i_debug_breakpoint_stall_unit (.clk_sys(clk_sys), .nrst(nrst),
        .link_active(link_active), .rd_on_fly_cmd(rd_on_fly_cmd), .wr_on_fly_cmd(wr_on_fly_cmd),
        .link_addr(link_addr), .link_wdata(link_wdata), .link_rdata(link_rdata),
        .dec_first(dec_first), .dec_valid_insn(dec_valid_insn), .dec_addr(dec_addr),
        .dec_opcode(dec_opcode), .data_strobe(data_strobe), .data_rd(data_rd),
        .data_addr(data_addr), .data_val(data_val), .data_stack(data_stack),
        .insn_end(insn_end), .reset_done(reset_done), .hw_watchdog(hw_watchdog),
        .flush_done(flush_done), .core_halt_signal(core_halt_signal),
        .decode_flush(decode_flush), .watchdog_freeze(watchdog_freeze),
        .vectors_to_rom(vectors_to_rom), .vectors_to_ram(vectors_to_ram));
    debug_host_model i_debug_host_model (.clk_sys(clk_sys), .rd_on_fly_cmd(rd_on_fly_cmd),
        .wr_on_fly_cmd(wr_on_fly_cmd), .link_addr(link_addr), .link_wdata(link_wdata),
        .rvalid(rvalid));
    // 25 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks++;
        if (seen !== want) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic halt(input logic e);
        check({7'h00, core_halt_signal}, {7'h00, e});
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        i_debug_host_model.wr(a, d);
    endtask
    // Reads note their expected answer for the monitor
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_debug_host_model.rd(a);
    endtask
    // Core decode pulse; stall shows in the same cycle
    task automatic fetch(input logic [23:0] a, input logic [7:0] op, input logic v, input logic e);
        @(posedge clk_sys);
        #1;
        dec_first = 1'b1;
        dec_addr = a;
        dec_opcode = op;
        dec_valid_insn = v;
        #5;
        halt(e);
        @(posedge clk_sys);
        #1;
        dec_first = 1'b0;
    endtask
    task automatic summarize;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Monitor: each read answer against the oldest note
    always @(posedge clk_sys) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) fail_count++;
            else check(link_rdata, exp_q.pop_front());
        end
    end
    // Hang guard
    initial begin
        #1ms;
        fail_count++;
        summarize();
    end
    initial begin
        {nrst, dec_first, dec_valid_insn, data_strobe, data_rd} = '0;
        {data_stack, insn_end, reset_done, hw_watchdog, flush_done} = '0;
        {dec_addr, data_addr, dec_opcode, data_val} = '0;
        link_active = 1'b1;
        seed = 32'hb5428131;
        repeat (10) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        @(posedge clk_sys);
        #1;
        reset_done = 1'b1;
        @(posedge clk_sys);
        #1;
        reset_done = 1'b0;
        halt(1'b1);
        for (i = 0; i < 10; i++) rd(16'h7f90 + 16'(i), rst_tab[i]);
        wr(16'h7f99, 8'h00);
        halt(1'b0);
        rd(16'h7f98, 8'h00);
        wr(16'h7f96, 8'hff);
        wr(16'h7f97, 8'hff);
        rd(16'h7f96, 8'hbe);
        rd(16'h7f97, 8'h05);
        check({6'h00, vectors_to_rom, vectors_to_ram}, 8'h03);
        wr(16'h7f96, 8'h00);
        wr(16'h7f97, 8'h00);
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(16'h7f93, seed[7:0]);
            rd(16'h7f93, seed[7:0]);
        end
        for (i = 0; i < 6; i++) wr(16'h7f90 + 16'(i), bk_tab[i]);
        $display("test registers done");
        // Fetch conditions: in range, invalid address, out of range, disabled codes
        for (i = 0; i < 8; i++) begin
            wr(16'h7f96, bc_tab[i]);
            fetch(fa_tab[i], 8'h9d, fv[i], fe[i]);
            if (fe[i]) begin
                rd(16'h7f98, 8'h02);
                wr(16'h7f99, 8'h00);
            end
        end
        // Step together with a fetch match
        wr(16'h7f96, 8'h08);
        wr(16'h7f98, 8'h40);
        fetch(24'h001008, 8'h9d, 1'b1, 1'b1);
        rd(16'h7f98, 8'h62);
        wr(16'h7f98, 8'h00);
        rd(16'h7f98, 8'h22);
        wr(16'h7f99, 8'h00);
        rd(16'h7f98, 8'h00);
        // Two-stage fetch match, then either-address mode, fetch on the second address only
        wr(16'h7f96, 8'h20);
        fetch(24'h001010, 8'h9d, 1'b1, 1'b0);
        fetch(24'h001000, 8'h9d, 1'b1, 1'b0);
        fetch(24'h001010, 8'h9d, 1'b1, 1'b1);
        rd(16'h7f98, 8'h04);
        wr(16'h7f99, 8'h00);
        wr(16'h7f96, 8'h28);
        fetch(24'h001010, 8'h9d, 1'b1, 1'b1);
        rd(16'h7f98, 8'h04);
        wr(16'h7f99, 8'h00);
        $display("test fetch and step done");
        // Data match on read only: write access passes, read access breaks
        wr(16'h7f96, 8'h04);
        for (i = 0; i < 2; i++) begin
            @(posedge clk_sys);
            #1;
            {data_strobe, data_rd, data_addr, data_val} = {1'b1, i[0], 24'h001000, 8'h10};
            @(posedge clk_sys);
            #1;
            {data_strobe, insn_end} = 2'b01;
            @(posedge clk_sys);
            #1;
            insn_end = 1'b0;
            halt(i[0]);
        end
        rd(16'h7f98, 8'h0a);
        wr(16'h7f99, 8'h00);
        // Break opcode ignored, then enabled
        fetch(24'h004000, 8'h8b, 1'b1, 1'b0);
        wr(16'h7f99, 8'h20);
        fetch(24'h004000, 8'h8b, 1'b1, 1'b1);
        rd(16'h7f99, 8'h38);
        wr(16'h7f99, 8'h00);
        rd(16'h7f99, 8'h00);
        $display("test data and soft break done");
        // Abort with watchdog freeze, then flush before resume
        wr(16'h7f96, 8'h80);
        wr(16'h7f99, 8'h08);
        check({7'h00, watchdog_freeze}, 8'h01);
        hw_watchdog = 1'b1;
        #1;
        check({7'h00, watchdog_freeze}, 8'h00);
        @(posedge clk_sys);
        #1;
        hw_watchdog = 1'b0;
        wr(16'h7f99, 8'h09);
        check({7'h00, decode_flush}, 8'h01);
        flush_done = 1'b1;
        @(posedge clk_sys);
        #1;
        flush_done = 1'b0;
        @(posedge clk_sys);
        #1;
        check({7'h00, decode_flush}, 8'h00);
        wr(16'h7f99, 8'h00);
        halt(1'b0);
        // Link down: abort refused
        link_active = 1'b0;
        wr(16'h7f99, 8'h08);
        halt(1'b0);
        link_active = 1'b1;
        rd(16'h7f99, 8'h00);
        rd(16'h7fa0, 8'h00);
        for (i = 0; i < 50 && exp_q.size() != 0; i++) @(posedge clk_sys);
        if (exp_q.size() != 0) fail_count++;
        $display("test abort and link done");
        summarize();
    end
endmodule // tb
bind debug_breakpoint_stall_unit debug_unit_checker i_debug_unit_checker (.clk_sys(clk_sys),
    .nrst(nrst), .link_active(link_active), .rd_on_fly_cmd(rd_on_fly_cmd),
    .wr_on_fly_cmd(wr_on_fly_cmd), .link_addr(link_addr), .link_wdata(link_wdata),
    .link_rdata(link_rdata), .hw_watchdog(hw_watchdog), .flush_done(flush_done),
    .core_halt_signal(core_halt_signal), .decode_flush(decode_flush),
    .watchdog_freeze(watchdog_freeze), .vectors_to_rom(vectors_to_rom),
    .vectors_to_ram(vectors_to_ram));
`default_nettype wire
